// >>> pps_pkg.sv
// Shared constants, register map and carrier types for the pattern sequencer.
package pps_pkg;
	// Register byte offsets on the APB bus.
	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_REPEAT = 12'h004;
	localparam logic [11:0] OFS_LENGTH = 12'h008;
	localparam logic [11:0] OFS_SEGLEN = 12'h00c;
	localparam logic [11:0] OFS_GEOM = 12'h010;
	localparam logic [11:0] OFS_SCRAMBLE = 12'h014;
	localparam logic [11:0] OFS_LOADCMD = 12'h018;
	localparam logic [11:0] OFS_LOADDATA = 12'h01c;
	localparam logic [11:0] OFS_TRIGGER = 12'h020;
	localparam logic [11:0] OFS_STATUS = 12'h024;
	localparam logic [11:0] OFS_ROWINFO = 12'h028;
	localparam logic [11:0] OFS_TOTAL = 12'h02c;
	// Field positions inside the packed registers.
	localparam int REP_B_POS = 16;
	localparam int LEN_B_POS = 16;
	localparam int SEG_PRBS_POS = 16;
	localparam int GEOM_BLK_POS = 16;
	localparam int LOAD_TGT_POS = 16;
	// Values after reset and documented limits.
	localparam logic [8:0] REP_MIN = 9'h001;
	localparam logic [7:0] ROWS_MIN = 8'h02;
	localparam logic [8:0] BLK_MIN = 9'h001;
	localparam logic [30:0] PRBS_SEED = 31'h7fffffff;
	localparam logic [6:0] SCR_SEED = 7'h7f;
	// Pattern modes, loop controls, mark ratios and sequencer states.
	typedef enum logic [1:0] {MODE_DATA = 2'h0, MODE_ALT = 2'h1,
		MODE_MIXED = 2'h2, MODE_SPARE = 2'h3} pps_mode_e;
	typedef enum logic [1:0] {LOOP_INT = 2'h0, LOOP_EXT = 2'h1,
		LOOP_MAN = 2'h2, LOOP_SPARE = 2'h3} pps_loop_e;
	typedef enum logic [1:0] {MARK_HALF = 2'h0, MARK_QUARTER = 2'h1,
		MARK_EIGHTH = 2'h2, MARK_ZERO = 2'h3} pps_mark_e;
	typedef enum logic [1:0] {GS_IDLE = 2'b00, GS_PROG = 2'b01,
		GS_PRBS = 2'b11, GS_SPARE = 2'b10} pps_state_e;
	// Control register layout, bit 0 is the low bit of mode.
	typedef struct packed {
		logic restart;
		logic shift3;
		pps_mark_e mark;
		logic [2:0] prbsSel;
		logic combo;
		logic burst;
		pps_loop_e loopCtl;
		logic invertedPolarity;
		pps_mode_e mode;
	} pps_ctrl_s;
	localparam int CTRL_W = $bits(pps_ctrl_s);
	localparam logic [CTRL_W-1:0] CTRL_RESET = 14'h2000;
endpackage

// >>> pps_fifo.sv
// Parameterised valid/ready FIFO for pattern words on their way to memory.
`timescale 1ns/1ps
module pps_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] store [DEPTH]; // Word storage.
	logic [AW:0] wrPtr; // Write pointer with wrap bit.
	logic [AW:0] rdPtr; // Read pointer with wrap bit.
	logic push;
	logic pop;
	// Full when the pointers differ only in the wrap bit.
	assign inReady = !((wrPtr[AW] != rdPtr[AW]) &&
		(wrPtr[AW-1:0] == rdPtr[AW-1:0]));
	assign outValid = wrPtr != rdPtr;
	assign push = inValid && inReady;
	assign pop = outValid && outReady;
	assign outData = store[rdPtr[AW-1:0]];
	// Pointers move only on accepted beats.
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			wrPtr <= '0;
			rdPtr <= '0;
		end
		else
		begin
			if (push)
				wrPtr <= wrPtr + 1'b1;
			if (pop)
				rdPtr <= rdPtr + 1'b1;
		end
	end
	// Storage has no reset; only written words are ever read.
	always_ff @(posedge clk)
	begin
		if (push)
			store[wrPtr[AW-1:0]] <= inData;
	end
endmodule

// >>> pps_sequencer.sv
// Programmable pattern sequencer: APB registers, pattern memory and generator.
// Behaviour
// - one is high, inverted polarity flips it.
// - committed pattern loads, loading flag stays up.
// - internal loop plays A then B forever.
// - external input picks pattern A or B.
// - manual trigger plays B, then back to A.
// - separate A and B repeats, 1 to 511.
// - external ignores repeats, manual ignores A repeat.
// - alternate and burst or combination exclude each other.
// - mixed rows are program then PRBS; blocks.
// - mixed pattern holds up to 511 blocks.
// - report blocks, row length, rows, total length.
// - PRBS period two to n minus one.
// - mark ratio half, quarter, eighth or zero.
// - AND shaping uses one or three bit shift.
// - PRBS7 scrambler only on selected areas.
// - first row program area never scrambled.
// - restart reseeds PRBS each pattern cycle.
`timescale 1ns/1ps
module pps_sequencer import pps_pkg::*; #(
	parameter int MEM_WORDS = 256
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic altSwitchIn,
	output logic serialOut,
	output logic patternLoading,
	output logic patternIsB
);
	localparam int WA_W = $clog2(MEM_WORDS);
	localparam int BIT_W = WA_W + 5;
	localparam logic [BIT_W-1:0] B_BASE = BIT_W'(MEM_WORDS * 16);

	// Clamp a written count to its legal minimum.
	function automatic logic [8:0] clampMin(input logic [8:0] v,
		input logic [8:0] lo);
		clampMin = (v < lo) ? lo : v;
	endfunction

	// Feedback bit of the selected n-stage PRBS polynomial.
	function automatic logic prbsFeedback(input logic [30:0] s,
		input logic [2:0] sel);
		case (sel)
			3'h0: prbsFeedback = s[6] ^ s[5];
			3'h1: prbsFeedback = s[8] ^ s[4];
			3'h2: prbsFeedback = s[9] ^ s[6];
			3'h3: prbsFeedback = s[10] ^ s[8];
			3'h4: prbsFeedback = s[14] ^ s[13];
			3'h5: prbsFeedback = s[19] ^ s[2];
			3'h6: prbsFeedback = s[22] ^ s[17];
			default: prbsFeedback = s[30] ^ s[27];
		endcase
	endfunction

	pps_ctrl_s ctrl; // Active configuration.
	pps_ctrl_s ctrlReq; // Configuration being written.
	logic [8:0] repA; // Loop count of pattern A.
	logic [8:0] repB; // Loop count of pattern B.
	logic [15:0] lenA; // Pattern A length in bits.
	logic [15:0] lenB; // Pattern B length in bits.
	logic [15:0] progLen; // Programmable bits per mixed row.
	logic [15:0] prbsLen; // PRBS bits per mixed row.
	logic [7:0] rows; // Rows per block, two at least.
	logic [8:0] blocks; // Blocks in the mixed pattern.
	logic scrEn; // Scrambler switched on.
	logic areaProg; // Scramble the programmable areas.
	logic areaPrbs; // Scramble the PRBS areas.
	logic [31:0] totalLen; // Mixed pattern length in bits.
	logic [16:0] rowLen; // Bits in one mixed row.
	logic refused; // Sticky: a control write was refused.
	logic manualPending; // Manual trigger waiting for the end of A.
	logic [31:0] mem [MEM_WORDS]; // Pattern memory, bit 0 sent first.
	logic [WA_W-1:0] loadAddr; // Next word to be loaded.
	logic [15:0] loadLeft; // Words still expected in this load.
	logic altMeta; // First synchroniser stage.
	logic altSync; // Synchronised A/B switch input.
	pps_state_e state;
	logic [BIT_W-1:0] bitPtr; // Offset inside the current pattern.
	logic [15:0] segCnt; // Bits left in the current segment.
	logic [7:0] rowCnt;
	logic [8:0] blkCnt;
	logic [8:0] repCnt; // Loops left for the current pattern.
	logic [30:0] lfsr;
	logic [6:0] markHist; // Past PRBS bits for AND shaping.
	logic [6:0] scr;
	// Bus decode and handshakes.
	logic setup;
	logic access;
	logic wrDone;
	logic addrOk;
	logic [31:0] readVal;
	logic fifoInReady;
	logic fifoOutValid;
	logic [31:0] fifoOutData;
	logic refuse;
	logic cfgChange;
	logic trigger;
	// Generator helpers.
	logic startOk;
	logic segLast;
	logic lastRow;
	logic lastBlk;
	logic cycleWrap;
	logic patEnd;
	logic nextB;
	logic [8:0] nextRep;
	logic consume;
	logic memBit;
	logic prbsBit;
	logic shaped;
	logic scrActive;
	logic genBit;
	logic [BIT_W-1:0] bitAddr;

	assign setup = psel && !penable;
	assign access = psel && penable;
	// A full FIFO stalls the bus so pattern words are never lost.
	assign pready = !(access && pwrite && paddr == OFS_LOADDATA &&
		!fifoInReady);
	assign wrDone = access && pwrite && pready && addrOk;
	assign pslverr = access && !addrOk;
	assign ctrlReq = pps_ctrl_s'(pwdata[CTRL_W-1:0]);
	assign refuse = ctrlReq.mode == MODE_ALT && (ctrlReq.burst || ctrlReq.combo);
	assign cfgChange = wrDone && (paddr == OFS_CTRL ||
		paddr == OFS_LENGTH || paddr == OFS_SEGLEN || paddr == OFS_GEOM);
	assign trigger = wrDone && paddr == OFS_TRIGGER && pwdata[0];

	// Word-aligned map; anything else answers with an error.
	always_comb
	begin
		addrOk = paddr[1:0] == 2'h0 && paddr <= OFS_TOTAL;
		case (paddr)
			OFS_CTRL: readVal = 32'(ctrl);
			OFS_REPEAT: readVal = {7'h0, repB, 7'h0, repA};
			OFS_LENGTH: readVal = {lenB, lenA};
			OFS_SEGLEN: readVal = {prbsLen, progLen};
			OFS_GEOM: readVal = {7'h0, blocks, 8'h0, rows};
			OFS_SCRAMBLE: readVal = {29'h0, areaPrbs, areaProg, scrEn};
			OFS_LOADCMD: readVal = {16'h0, loadLeft};
			OFS_STATUS: readVal = {28'h0, manualPending, refused,
				patternIsB, patternLoading};
			OFS_ROWINFO: readVal = {15'h0, rowLen};
			OFS_TOTAL: readVal = totalLen;
			default: readVal = 32'h0;
		endcase
	end

	// Read data is captured in the setup phase and stands for the access.
	always_ff @(posedge clk)
	begin
		if (reset)
			prdata <= 32'h0;
		else if (setup && !pwrite)
			prdata <= readVal;
	end

	// Configuration registers; lengths are written whole.
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			ctrl <= pps_ctrl_s'(CTRL_RESET);
			repA <= REP_MIN;
			repB <= REP_MIN;
			lenA <= 16'h0;
			lenB <= 16'h0;
			progLen <= 16'h0;
			prbsLen <= 16'h0;
			rows <= ROWS_MIN;
			blocks <= BLK_MIN;
			{areaPrbs, areaProg, scrEn} <= 3'h0;
		end
		else if (wrDone)
		begin
			case (paddr)
				OFS_CTRL: if (!refuse) ctrl <= ctrlReq;
				OFS_REPEAT:
				begin
					repA <= clampMin(pwdata[8:0], REP_MIN);
					repB <= clampMin(pwdata[REP_B_POS+:9], REP_MIN);
				end
				OFS_LENGTH:
				begin
					lenA <= pwdata[15:0];
					lenB <= pwdata[LEN_B_POS+:16];
				end
				OFS_SEGLEN:
				begin
					progLen <= pwdata[15:0];
					prbsLen <= pwdata[SEG_PRBS_POS+:16];
				end
				OFS_GEOM:
				begin
					rows <= (pwdata[7:0] < ROWS_MIN) ? ROWS_MIN : pwdata[7:0];
					blocks <= clampMin(pwdata[GEOM_BLK_POS+:9], BLK_MIN);
				end
				OFS_SCRAMBLE: {areaPrbs, areaProg, scrEn} <= pwdata[2:0];
				default: ;
			endcase
		end
	end

	// Status figures are registered so the product stays off the bus path.
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			rowLen <= 17'h0;
			totalLen <= 32'h0;
		end
		else
		begin
			rowLen <= 17'(progLen) + 17'(prbsLen);
			totalLen <= 32'(32'(blocks) * 32'(rows) * 32'(rowLen));
		end
	end

	// Sticky refusal flag and manual trigger; a new event beats the clear.
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			refused <= 1'b0;
			manualPending <= 1'b0;
		end
		else
		begin
			refused <= (wrDone && paddr == OFS_CTRL && refuse) ||
				(refused && !(setup && !pwrite && paddr == OFS_STATUS));
			manualPending <= trigger || (manualPending && !consume);
		end
	end

	pps_fifo #(.WIDTH(32), .DEPTH(16)) loadFifo (
		.clk(clk),
		.reset(reset),
		.inValid(wrDone && paddr == OFS_LOADDATA),
		.inReady(fifoInReady),
		.inData(pwdata),
		.outValid(fifoOutValid),
		.outReady(patternLoading),
		.outData(fifoOutData)
	);

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			patternLoading <= 1'b0;
			loadLeft <= 16'h0;
			loadAddr <= '0;
		end
		else if (wrDone && paddr == OFS_LOADCMD)
		begin
			patternLoading <= pwdata[15:0] != 16'h0;
			loadLeft <= pwdata[15:0];
			loadAddr <= pwdata[LOAD_TGT_POS] ? WA_W'(MEM_WORDS / 2) : '0;
		end
		else if (patternLoading && fifoOutValid)
		begin
			loadLeft <= loadLeft - 16'h1;
			loadAddr <= loadAddr + 1'b1;
			patternLoading <= loadLeft != 16'h1;
		end
	end

	// Pattern memory takes words only while a load is open.
	always_ff @(posedge clk)
	begin
		if (patternLoading && fifoOutValid)
			mem[loadAddr] <= fifoOutData;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			altMeta <= 1'b0;
			altSync <= 1'b0;
		end
		else
		begin
			altMeta <= altSwitchIn;
			altSync <= altMeta;
		end
	end

	assign startOk = ctrl.mode == MODE_MIXED ?
		(progLen != 16'h0 && prbsLen != 16'h0) : lenA != 16'h0;
	assign segLast = segCnt == 16'h1;
	assign lastRow = rowCnt == rows - 8'h1;
	assign lastBlk = blkCnt == blocks - 9'h1;
	assign cycleWrap = state == GS_PRBS && segLast && lastRow && lastBlk;
	assign patEnd = state == GS_PROG && segLast && ctrl.mode != MODE_MIXED;
	assign bitAddr = (patternIsB ? B_BASE : '0) + bitPtr;
	assign memBit = mem[bitAddr[BIT_W-1:5]][bitAddr[4:0]];

	// Choice of the next pattern at the end of each pass.
	always_comb
	begin
		nextB = 1'b0;
		nextRep = repA;
		consume = 1'b0;
		if (ctrl.mode == MODE_ALT)
		begin
			case (ctrl.loopCtl)
				LOOP_EXT:
				begin
					nextB = altSync;
				end
				LOOP_MAN:
				begin
					if (!patternIsB)
					begin
						nextB = manualPending;
						consume = manualPending;
						nextRep = repB;
					end
					else
					begin
						// Back to A after the last B pass, never a count of 0.
						nextB = repCnt != 9'h1;
						nextRep = (repCnt != 9'h1) ? repCnt - 9'h1 : repA;
					end
				end
				default:
				begin
					nextB = (repCnt == 9'h1) ? !patternIsB : patternIsB;
					nextRep = (repCnt != 9'h1) ? repCnt - 9'h1 :
						(patternIsB ? repA : repB);
				end
			endcase
			consume = consume && patEnd;
		end
	end

	// Pattern walker: whole passes in data and alternate, rows in mixed.
	always_ff @(posedge clk)
	begin
		if (reset || patternLoading || cfgChange)
		begin
			state <= GS_IDLE;
			bitPtr <= '0;
			segCnt <= 16'h0;
			rowCnt <= 8'h0;
			blkCnt <= 9'h0;
			repCnt <= REP_MIN;
			patternIsB <= 1'b0;
		end
		else
		begin
			case (state)
				GS_IDLE:
				begin
					if (startOk)
					begin
						state <= GS_PROG;
						segCnt <= ctrl.mode == MODE_MIXED ? progLen : lenA;
						repCnt <= repA;
					end
				end
				GS_PROG:
				begin
					bitPtr <= bitPtr + 1'b1;
					segCnt <= segCnt - 16'h1;
					if (segLast && ctrl.mode == MODE_MIXED)
					begin
						state <= GS_PRBS;
						segCnt <= prbsLen;
					end
					else if (patEnd)
					begin
						bitPtr <= '0;
						patternIsB <= nextB;
						repCnt <= nextRep;
						segCnt <= nextB ? lenB : lenA;
					end
				end
				GS_PRBS:
				begin
					segCnt <= segCnt - 16'h1;
					if (segLast)
					begin
						state <= GS_PROG;
						segCnt <= progLen;
						rowCnt <= lastRow ? 8'h0 : rowCnt + 8'h1;
						if (lastRow)
							blkCnt <= lastBlk ? 9'h0 : blkCnt + 9'h1;
						if (cycleWrap)
							bitPtr <= '0;
					end
				end
				default: state <= GS_IDLE;
			endcase
		end
	end

	// PRBS register; it only advances while a PRBS segment is sent.
	always_ff @(posedge clk)
	begin
		if (reset || state == GS_IDLE)
		begin
			lfsr <= PRBS_SEED;
			markHist <= 7'h0;
		end
		else if (cycleWrap && ctrl.restart)
			lfsr <= PRBS_SEED;
		else if (state == GS_PRBS)
		begin
			lfsr <= {lfsr[29:0], prbsBit};
			markHist <= {markHist[5:0], prbsBit};
		end
	end

	assign prbsBit = prbsFeedback(lfsr, ctrl.prbsSel);

	// Mark shaping ANDs the sequence with delayed copies of itself.
	always_comb
	begin
		case (ctrl.mark)
			MARK_HALF: shaped = prbsBit;
			MARK_QUARTER: shaped = prbsBit &
				(ctrl.shift3 ? markHist[2] : markHist[0]);
			MARK_EIGHTH: shaped = prbsBit &
				(ctrl.shift3 ? markHist[2] & markHist[5] :
				markHist[0] & markHist[1]);
			default: shaped = 1'b0;
		endcase
	end

	assign scrActive = scrEn && ctrl.mode == MODE_MIXED &&
		((state == GS_PROG && areaProg && rowCnt != 8'h0) ||
		(state == GS_PRBS && areaPrbs));
	assign genBit = (state == GS_PRBS ? shaped : memBit) ^
		(scrActive & (scr[6] ^ scr[5]));

	// Additive PRBS7 scrambler runs on every sent bit.
	always_ff @(posedge clk)
	begin
		if (reset || state == GS_IDLE)
			scr <= SCR_SEED;
		else
			scr <= {scr[5:0], scr[6] ^ scr[5]};
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			serialOut <= 1'b0;
		else
			serialOut <= (state != GS_IDLE && genBit) ^ ctrl.invertedPolarity;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	property p_idleLevel;
		$past(state) == GS_IDLE |-> serialOut == $past(ctrl.invertedPolarity);
	endproperty
	a_idleLevel: assert property (p_idleLevel)
		else $error("Idle line does not show logical zero.");
	property p_loadStart;
		wrDone && paddr == OFS_LOADCMD && pwdata[15:0] != 16'h0 |=>
			patternLoading ##1 state == GS_IDLE;
	endproperty
	a_loadStart: assert property (p_loadStart)
		else $error("Commit did not raise loading and halt output.");
	property p_switchAfterA;
		patEnd && ctrl.mode == MODE_ALT && ctrl.loopCtl == LOOP_INT &&
			!patternIsB && repCnt == 9'h1 && !cfgChange |=>
			patternIsB && repCnt == $past(repB);
	endproperty
	a_switchAfterA: assert property (p_switchAfterA)
		else $error("Internal loop did not move to B.");
	property p_extFollow;
		patEnd && ctrl.mode == MODE_ALT && ctrl.loopCtl == LOOP_EXT &&
			!cfgChange |=> patternIsB == $past(altSync);
	endproperty
	a_extFollow: assert property (p_extFollow)
		else $error("External switch not followed.");
	property p_manualB;
		ctrl.loopCtl == LOOP_MAN && $rose(patternIsB) |->
			$past(manualPending) && !manualPending;
	endproperty
	a_manualB: assert property (p_manualB)
		else $error("Pattern B started without a trigger.");
	property p_repRange;
		repA != 9'h0 && repB != 9'h0 && repCnt != 9'h0;
	endproperty
	a_repRange: assert property (p_repRange)
		else $error("Loop count fell out of range.");
	property p_exclusive;
		ctrl.mode == MODE_ALT |-> !ctrl.burst && !ctrl.combo;
	endproperty
	a_exclusive: assert property (p_exclusive)
		else $error("Alternate set together with burst or combination.");
	property p_rowSplit;
		state == GS_PROG && segLast && ctrl.mode == MODE_MIXED && !cfgChange
			&& !patternLoading |=> state == GS_PRBS && segCnt == $past(prbsLen);
	endproperty
	a_rowSplit: assert property (p_rowSplit)
		else $error("Row did not continue into its PRBS segment.");
	property p_firstRowClear;
		ctrl.mode == MODE_MIXED && state == GS_PROG && rowCnt == 8'h0 |=>
			serialOut == ($past(memBit) ^ $past(ctrl.invertedPolarity));
	endproperty
	a_firstRowClear: assert property (p_firstRowClear)
		else $error("First row program area was scrambled.");
	property p_restartSeed;
		cycleWrap && ctrl.restart && !cfgChange && !patternLoading |=>
			lfsr == PRBS_SEED;
	endproperty
	a_restartSeed: assert property (p_restartSeed)
		else $error("PRBS not reseeded at cycle wrap.");
	c_cycleWrap: cover property (cycleWrap);
	c_manualRun: cover property (consume ##[1:600] $fell(patternIsB));
	c_loadDone: cover property ($fell(patternLoading));
	c_stall: cover property (access && !pready);
endmodule

// >>> pps_dut_model.sv
// Far-side model: receives the serial pattern and drives the A/B select.
`timescale 1ns/1ps
module pps_dut_model (
	input wire logic clk,
	input wire logic reset,
	input wire logic serialIn,
	input wire logic wantB,
	output logic altSwitch,
	output logic [3:0] onesSeen
);
	// Last eight received bits, newest at bit 0.
	logic [7:0] window;

	// Shift in one bit per clock, as the generator sends one per clock.
	always_ff @(posedge clk)
	begin
		if (reset)
			window <= 8'h00;
		else
			window <= {window[6:0], serialIn};
	end

	// external party selects
	// The select pin changes only just after an edge, like a real source.
	always_ff @(posedge clk)
	begin
		if (reset)
			altSwitch <= 1'b0;
		else
			altSwitch <= wantB;
	end

	// Ones in any eight bits of a repeating 8-bit pattern are fixed,
	// so the count needs no alignment to the pattern start.
	assign onesSeen = 4'($countones(window));
endmodule

// >>> tb_top.sv
// Self-checking testbench for the pattern sequencer.
`timescale 1ns/1ps
module tb_top;
	import pps_pkg::*;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, altSwitch, serialOut, patternLoading, patternIsB;
	logic wantB = 1'b0;
	logic [3:0] onesSeen;
	int miscompares = 0;
	int checksDone = 0;
	int cycles = 0;
	logic [31:0] q;
	logic e;
	int n;

	pps_sequencer dut (.clk(clk), .reset(reset), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .altSwitchIn(altSwitch),
		.serialOut(serialOut), .patternLoading(patternLoading),
		.patternIsB(patternIsB));
	pps_dut_model farEnd (.clk(clk), .reset(reset), .serialIn(serialOut),
		.wantB(wantB), .altSwitch(altSwitch), .onesSeen(onesSeen));

	// Clock of 10 ns period.
	always #5 clk = ~clk;

	// Prints the counts and the verdict, then ends the run.
	task automatic wrap_up;
		$display("checks %0d, mismatches %0d", checksDone, miscompares);
		if (miscompares == 0 && checksDone > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// A hang anywhere is cut short here and counted as a mismatch.
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			miscompares++;
			wrap_up;
		end
	end

	// Compares one seen value with its expectation.
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checksDone++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("unexpected at %0t: seen %h expected %h", $time,
				seen, exp);
		end
	endtask

	// One APB transfer; held until pready is sampled high.
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
		begin
			@(posedge clk);
			k++;
		end
		while (pready !== 1'b1 && k < 1000);
		// A transfer that never completes counts against the run.
		if (k >= 1000)
			miscompares++;
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Reads a register and compares it.
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(q, exp);
	endtask

	// Loads one word into pattern A (tgt 0) or B (tgt 1).
	task automatic load(input logic tgt, input logic [31:0] w);
		apb(1'b1, OFS_LOADCMD, {15'h0, tgt, 16'h0001});
		@(negedge clk);
		check({31'h0, patternLoading}, 32'h1);
		apb(1'b1, OFS_LOADDATA, w);
		n = 0;
		while (patternLoading !== 1'b0 && n < 200)
		begin
			@(negedge clk);
			n++;
		end
		check({31'h0, patternLoading}, 32'h0);
	endtask

	// Counts how long patternIsB stays at level v once it gets there.
	task automatic span(input logic v, input int exp);
		n = 0;
		while (patternIsB !== v && n < 500)
		begin
			@(negedge clk);
			n++;
		end
		n = 0;
		while (patternIsB === v && n < 500)
		begin
			@(negedge clk);
			n++;
		end
		check(n, exp);
	endtask

	// Counts the ones on the serial line over len bits.
	task automatic tally(input int len, input int exp);
		n = 0;
		repeat (8) @(negedge clk);
		repeat (len)
		begin
			@(negedge clk);
			n += serialOut;
		end
		check(n, exp);
	endtask

	// Compares two back-to-back 96-bit stretches of the serial line.
	task automatic twice(input logic [31:0] same);
		logic [191:0] w;
		repeat (8) @(negedge clk);
		for (int i = 0; i < 192; i++)
		begin
			@(negedge clk);
			w[i] = serialOut;
		end
		check({31'h0, w[95:0] === w[191:96]}, same);
	endtask

	initial
	begin
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		rd(OFS_CTRL, 32'h2000);
		rd(OFS_REPEAT, 32'h00010001);
		apb(1'b1, OFS_REPEAT, 32'h01ff0000);
		rd(OFS_REPEAT, 32'h01ff0001);
		apb(1'b0, 12'h030, 32'h0);
		check({31'h0, e}, 32'h1);
		// Data mode, 8-bit pattern with a single one.
		apb(1'b1, OFS_LENGTH, 32'h00080008);
		load(1'b0, 32'h00000001);
		load(1'b1, 32'h000000ff);
		repeat (40) @(negedge clk);
		check(onesSeen, 32'h1);
		apb(1'b1, OFS_CTRL, 32'h2004);
		repeat (40) @(negedge clk);
		check(onesSeen, 32'h7);
		// Alternate plus burst is refused and flagged.
		apb(1'b1, OFS_CTRL, 32'h2021);
		rd(OFS_CTRL, 32'h2004);
		apb(1'b0, OFS_STATUS, 32'h0);
		check(q & 32'h4, 32'h4);
		// Internal loop: A three passes, B two passes of 8 bits.
		apb(1'b1, OFS_REPEAT, 32'h00020003);
		apb(1'b1, OFS_CTRL, 32'h2001);
		span(1'b1, 16);
		span(1'b0, 24);
		// Manual loop: A stays until triggered, then B twice.
		apb(1'b1, OFS_CTRL, 32'h2011);
		repeat (60) @(negedge clk);
		check({31'h0, patternIsB}, 32'h0);
		apb(1'b1, OFS_TRIGGER, 32'h1);
		span(1'b1, 16);
		// External loop follows the select pin, repeats ignored.
		apb(1'b1, OFS_CTRL, 32'h2009);
		wantB <= 1'b1;
		repeat (60) @(negedge clk);
		check({31'h0, patternIsB}, 32'h1);
		wantB <= 1'b0;
		repeat (60) @(negedge clk);
		check({31'h0, patternIsB}, 32'h0);
		// Largest block count is kept, a row count below two is raised.
		apb(1'b1, OFS_GEOM, 32'h01ff0000);
		rd(OFS_GEOM, 32'h01ff0002);
		// Mixed geometry: 4 program bits, 12 PRBS bits, 3 rows, 2 blocks.
		apb(1'b1, OFS_SEGLEN, 32'h000c0004);
		apb(1'b1, OFS_GEOM, 32'h00020003);
		apb(1'b1, OFS_CTRL, 32'h2c02);
		rd(OFS_ROWINFO, 32'd16);
		rd(OFS_TOTAL, 32'd96);
		// Zero mark ratio: only program bit 0 is set in a 96-bit cycle.
		tally(96, 1);
		apb(1'b1, OFS_CTRL, 32'h2c06);
		tally(96, 95);
		// Restart repeats each cycle, consecutive does not.
		apb(1'b1, OFS_CTRL, 32'h2002);
		twice(32'h1);
		apb(1'b1, OFS_CTRL, 32'h0002);
		twice(32'h0);
		// Scrambling breaks the 96-bit repetition of a restarted cycle.
		apb(1'b1, OFS_SCRAMBLE, 32'h7);
		apb(1'b1, OFS_CTRL, 32'h2c02);
		twice(32'h0);
		wrap_up;
	end
endmodule
